// file: rtl/sto_monitor.sv
// dual-channel torque-off supervisor: gates the power stage, flags mismatch, latches faults
// assumes rstn is the power-on reset and supply_ok comes from an external voltage monitor
//
// Summary of operation
// - both inputs low: stage off, flags zero
// - trip signalled to processor and safety side
// - both high: firmware may enable, report one
// - inputs disagree: stage off, mismatch flag set
// - long disagreement latches fault until power cycle
// - latched: stage off, report is input NOR
// - bad logic supply forces safe state until recovery
// - after power-on with inputs high, enable works
// - inputs and flags readable by software
// - gating independent of firmware, firmware only notified
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module sto_monitor #(
  parameter int unsigned MISMATCH_CYC = sto_pkg::MISMATCH_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       torque_off_input_a,
  input  wire logic                       torque_off_input_b,
  input  wire logic                       supply_ok,
  input  wire logic [sto_pkg::ADDR_W-1:0] addr,
  input  wire logic [sto_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [sto_pkg::DATA_W-1:0] rdata,
  output logic                            power_stage_en,
  output logic                            torque_off_report_flag,
  output logic                            mismatch_fault_flag,
  output logic                            supply_fault_flag,
  output logic                            safety_trip,
  output logic                            irq
);

  localparam int unsigned CNT_W = $clog2(MISMATCH_CYC + 1);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ENABLED,
    ST_MISMATCH,
    ST_LATCHED,
    ST_SUPPLY
  } sto_state_e;

  typedef struct packed {
    sto_state_e                 mode;
    logic [CNT_W-1:0]           cnt;
    logic [CNT_W-1:0]           mis_run;
    logic                       en_req;
    logic [sto_pkg::EV_W-1:0]   ev_stat;
    logic [sto_pkg::EV_W-1:0]   ev_en;
    logic [sto_pkg::DATA_W-1:0] rdata;
    logic                       pwr;
    sto_pkg::sto_flags_s        flags;
    logic                       trip;
    logic                       irq;
  } sto_core_s;

  sto_core_s   st_q;
  sto_core_s   st_d;
  sto_pkg::sto_req_s req;
  logic [2:0]  pins_sync;
  logic        in_a;
  logic        in_b;
  logic        sup_ok;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // supply reads as bad for two clocks after reset, so a power-on passes the supply state once
  // pins cross from outside the clock domain
  sto_sync2 #(
    .W (3)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({supply_ok, torque_off_input_b, torque_off_input_a}),
    .q    (pins_sync)
  );

  assign in_a   = pins_sync[0];
  assign in_b   = pins_sync[1];
  assign sup_ok = pins_sync[2];

  function automatic logic [sto_pkg::DATA_W-1:0] status_word(
    input logic in_a_f,
    input logic in_b_f,
    input sto_pkg::sto_flags_s fl,
    input logic pwr_f
  );
    logic [sto_pkg::DATA_W-1:0] w;
    w = '0;
    w[sto_pkg::ST_IN_A]     = in_a_f;
    w[sto_pkg::ST_IN_B]     = in_b_f;
    w[sto_pkg::ST_REPORT]   = fl.report;
    w[sto_pkg::ST_MISMATCH] = fl.mismatch;
    w[sto_pkg::ST_SUPPLY]   = fl.safe_supply;
    w[sto_pkg::ST_LATCHED]  = fl.latched;
    w[sto_pkg::ST_PWR_EN]   = pwr_f;
    return w;
  endfunction

  always_comb begin
    logic [sto_pkg::EV_W-1:0] ev;
    ev   = '0;
    st_d = st_q;

    // mode transitions; supply fault outranks every mode but the latch, latch survives recovery
    case (st_q.mode)
      ST_OFF, ST_ENABLED: begin
        if (in_a != in_b) begin
          st_d.mode = ST_MISMATCH;
        end else if (in_a) begin
          st_d.mode = ST_ENABLED;
        end else begin
          st_d.mode = ST_OFF;
        end
        st_d.cnt = '0;
      end
      ST_MISMATCH: begin
        if (in_a == in_b) begin
          st_d.mode = in_a ? ST_ENABLED : ST_OFF;
          st_d.cnt  = '0;
        end else if (st_q.cnt >= CNT_W'(MISMATCH_CYC - 1)) begin
          st_d.mode = ST_LATCHED;
          ev[sto_pkg::EV_LATCH] = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + CNT_W'(1);
        end
      end
      ST_LATCHED: begin
        st_d.mode = ST_LATCHED;
      end
      ST_SUPPLY: begin
        // returns through the off state so inputs are re-evaluated
        st_d.mode = ST_OFF;
        st_d.cnt  = '0;
      end
      default: begin
        st_d.mode = ST_OFF;
        st_d.cnt  = '0;
      end
    endcase

    if (!sup_ok && st_q.mode != ST_LATCHED) begin
      st_d.mode = ST_SUPPLY;
      st_d.cnt  = '0;
    end else if (st_q.mode == ST_SUPPLY && !sup_ok) begin
      st_d.mode = ST_SUPPLY;
    end

    // outputs derived from the next mode and current synchronised pins
    st_d.flags.report      = 1'b0;
    st_d.flags.mismatch    = 1'b0;
    st_d.flags.latched     = 1'b0;
    st_d.flags.safe_supply = 1'b0;
    st_d.pwr               = 1'b0;
    case (st_d.mode)
      ST_OFF: begin
        st_d.flags.report = 1'b0;
      end
      ST_ENABLED: begin
        st_d.flags.report = 1'b1;
        // hardware gate: firmware request alone cannot bypass it
        st_d.pwr = st_q.en_req;
      end
      ST_MISMATCH: begin
        st_d.flags.mismatch = 1'b1;
      end
      ST_LATCHED: begin
        st_d.flags.mismatch = 1'b1;
        st_d.flags.latched  = 1'b1;
        st_d.flags.report   = ~(in_a | in_b);
      end
      ST_SUPPLY: begin
        st_d.flags.safe_supply = 1'b1;
      end
      default: begin
        st_d.pwr = 1'b0;
      end
    endcase
    st_d.trip = ~st_d.pwr;

    // run length kept apart from cnt so the latch timing check does not trust it
    if (st_q.mode != ST_MISMATCH) begin
      st_d.mis_run = '0;
    end else if (st_q.mis_run != CNT_W'(MISMATCH_CYC)) begin
      st_d.mis_run = st_q.mis_run + CNT_W'(1);
    end

    // events; set wins over a same-cycle clear
    ev[sto_pkg::EV_TRIP]     = st_d.trip & ~st_q.trip;
    ev[sto_pkg::EV_MISMATCH] = st_d.flags.mismatch & ~st_q.flags.mismatch;
    ev[sto_pkg::EV_SUPPLY]   = st_d.flags.safe_supply & ~st_q.flags.safe_supply;

    if (req.wr && req.addr == sto_pkg::OFF_CONTROL) begin
      st_d.en_req = req.wdata[sto_pkg::CT_ENABLE];
    end
    if (req.wr && req.addr == sto_pkg::OFF_IRQ_EN) begin
      st_d.ev_en = req.wdata[sto_pkg::EV_W-1:0];
    end
    if (req.wr && req.addr == sto_pkg::OFF_IRQ_CLR) begin
      st_d.ev_stat = st_q.ev_stat & ~req.wdata[sto_pkg::EV_W-1:0];
    end
    st_d.ev_stat = st_d.ev_stat | ev;

    st_d.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        sto_pkg::OFF_STATUS:   st_d.rdata = status_word(in_a, in_b, st_q.flags, st_q.pwr);
        sto_pkg::OFF_CONTROL:  st_d.rdata = {31'h0000_0000, st_q.en_req};
        sto_pkg::OFF_IRQ_STAT: st_d.rdata = {28'h000_0000, st_q.ev_stat};
        sto_pkg::OFF_IRQ_EN:   st_d.rdata = {28'h000_0000, st_q.ev_en};
        default:               st_d.rdata = '0;
      endcase
    end
    st_d.irq = |(st_d.ev_stat & st_d.ev_en);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q         <= '0;
      st_q.mode    <= ST_OFF;
      st_q.trip    <= 1'b1;
      st_q.en_req  <= sto_pkg::CONTROL_RST[sto_pkg::CT_ENABLE];
      st_q.ev_stat <= sto_pkg::EV_RST;
      st_q.ev_en   <= sto_pkg::EV_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata                  = st_q.rdata;
  assign power_stage_en         = st_q.pwr;
  assign torque_off_report_flag = st_q.flags.report;
  assign mismatch_fault_flag    = st_q.flags.mismatch;
  assign supply_fault_flag      = st_q.flags.safe_supply;
  assign safety_trip            = st_q.trip;
  assign irq                    = st_q.irq;

  property p_both_low;
    @(posedge clk) disable iff (!rstn)
      (st_q.mode == ST_OFF) |-> (!power_stage_en && !torque_off_report_flag
                                 && !mismatch_fault_flag);
  endproperty
  a_both_low: assert property (p_both_low) else $error("off state drives stage or flags");

  property p_trip;
    @(posedge clk) disable iff (!rstn)
      safety_trip == !power_stage_en;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not inverse of stage enable");

  property p_enabled;
    @(posedge clk) disable iff (!rstn)
      (in_a && in_b && st_q.mode == ST_ENABLED && st_q.en_req && sup_ok)
        |=> power_stage_en;
  endproperty
  a_enabled: assert property (p_enabled) else $error("enable request not honoured");

  property p_mismatch;
    @(posedge clk) disable iff (!rstn)
      (in_a != in_b && sup_ok && st_q.mode != ST_LATCHED && st_q.mode != ST_SUPPLY)
        |=> (mismatch_fault_flag && !power_stage_en);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("disagreement not flagged");

  // the latch must follow exactly MISMATCH_CYC cycles of disagreement, counted apart
  property p_latch_bound;
    @(posedge clk) disable iff (!rstn)
      $rose(st_q.mode == ST_LATCHED)
        |-> st_q.mis_run == CNT_W'(MISMATCH_CYC);
  endproperty
  a_latch_bound: assert property (p_latch_bound) else $error("latched too early");

  property p_latched;
    @(posedge clk) disable iff (!rstn)
      (st_q.mode == ST_LATCHED) |=> (st_q.mode == ST_LATCHED && !power_stage_en
        && mismatch_fault_flag && torque_off_report_flag == ~($past(in_a) | $past(in_b)));
  endproperty
  a_latched: assert property (p_latched) else $error("latched state not held");

  property p_supply;
    @(posedge clk) disable iff (!rstn)
      (!sup_ok && st_q.mode != ST_LATCHED) |=> (supply_fault_flag && !power_stage_en);
  endproperty
  a_supply: assert property (p_supply) else $error("supply fault not forced safe");

  property p_irq;
    @(posedge clk) disable iff (!rstn)
      $rose(mismatch_fault_flag) |-> st_q.ev_stat[sto_pkg::EV_MISMATCH];
  endproperty
  a_irq: assert property (p_irq) else $error("mismatch event not recorded");

  property p_read_idle;
    @(posedge clk) disable iff (!rstn)
      !rd |=> rdata == '0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");

  // the stage may only be on while both channels agree high, whatever firmware asks
  property p_stage_gate;
    @(posedge clk) disable iff (!rstn)
      power_stage_en |-> (torque_off_report_flag && !mismatch_fault_flag && !supply_fault_flag);
  endproperty
  a_stage_gate: assert property (p_stage_gate) else $error("stage on without both inputs");

endmodule

// file: rtl/sto_pkg.sv
// package for the dual-channel torque-off supervisor: register map, fields, timing
// assumes a 40 MHz system clock and a simple strobe register port
package sto_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  // mismatch window: the latch must fire between 1.4 s and 3.4 s
  localparam int unsigned MISMATCH_MIN_MS = 1400;
  localparam int unsigned MISMATCH_MAX_MS = 3400;
  // fire at 2.4 s, safely inside the window
  localparam int unsigned MISMATCH_MS     = 2400;
  localparam int unsigned MISMATCH_CYC    = (CLK_HZ / 1000) * MISMATCH_MS;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  localparam logic [3:0] OFF_STATUS   = 4'h0;
  localparam logic [3:0] OFF_CONTROL  = 4'h4;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFF_IRQ_EN   = 4'hC;
  localparam logic [3:0] OFF_IRQ_CLR  = 4'h8;

  // status register bit positions
  localparam int unsigned ST_IN_A     = 0;
  localparam int unsigned ST_IN_B     = 1;
  localparam int unsigned ST_REPORT   = 2;
  localparam int unsigned ST_MISMATCH = 3;
  localparam int unsigned ST_SUPPLY   = 4;
  localparam int unsigned ST_LATCHED  = 5;
  localparam int unsigned ST_PWR_EN   = 6;

  // control register: bit 0 is the firmware motor enable request
  localparam int unsigned CT_ENABLE   = 0;
  localparam logic [DATA_W-1:0] CONTROL_RST = 32'h0000_0000;

  // interrupt event bits
  localparam int unsigned EV_TRIP     = 0;
  localparam int unsigned EV_MISMATCH = 1;
  localparam int unsigned EV_LATCH    = 2;
  localparam int unsigned EV_SUPPLY   = 3;
  localparam int unsigned EV_W        = 4;
  localparam logic [EV_W-1:0] EV_RST  = 4'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sto_req_s;

  typedef struct packed {
    logic report;
    logic mismatch;
    logic latched;
    logic safe_supply;
  } sto_flags_s;

endpackage

// file: rtl/sto_sync2.sv
// two-flop synchroniser for the asynchronous torque-off and supply pins
// assumes inputs are static levels; glitches shorter than a clock are not filtered
`timescale 1ns/1ps
module sto_sync2 #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sto_sync_s;

  sto_sync_s st_q;
  sto_sync_s st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

// file: verif/safe_torque_off_monitor_bench.sv
// self-checking bench for the dual-channel torque-off supervisor
// assumes a 40 MHz clock and a shortened mismatch timeout
`timescale 1ns/1ps
module safe_torque_off_monitor_bench;
  localparam int unsigned MCYC = 20;
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic [1:0]  want      = 2'b00;
  logic        supply_ok = 1'b1;
  logic [3:0]  addr      = 4'h0;
  logic [31:0] wdata     = 32'h0000_0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [31:0] rdata;
  logic        pin_a, pin_b, pwr, rep, mis, sfl, trip, irq;
  int          errors    = 0;
  int          n_tests   = 0;

  always #12.5 clk = ~clk;

  sto_ctrl_model u_ctl (.clk(clk), .rstn(rstn), .want(want), .out_a(pin_a), .out_b(pin_b));

  sto_monitor #(.MISMATCH_CYC(MCYC)) DUT (
    .clk(clk), .rstn(rstn), .torque_off_input_a(pin_a), .torque_off_input_b(pin_b),
    .supply_ok(supply_ok), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .power_stage_en(pwr), .torque_off_report_flag(rep), .mismatch_fault_flag(mis),
    .supply_fault_flag(sfl), .safety_trip(trip), .irq(irq)
  );

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // flag order: power enable, report, mismatch, supply fault, trip
  task automatic fl(input logic [4:0] e);
    chk({27'h000_0000, pwr, rep, mis, sfl, trip}, {27'h000_0000, e});
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  // model edge, two sync flops and the state register need margin
  task automatic pins(input logic a, input logic b, input int n);
    @(posedge clk);
    want <= {b, a};
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_off;
    pins(1'b0, 1'b0, 6);
    fl(5'b00001);
    rd_chk(sto_pkg::OFF_STATUS, 32'h0000_0000);
    $display("test off done");
  endtask

  task automatic t_on;
    wr_reg(sto_pkg::OFF_CONTROL, 32'h0000_0001);
    pins(1'b1, 1'b1, 6);
    fl(5'b11000);
    rd_chk(sto_pkg::OFF_STATUS, 32'h0000_0047);
    rd_chk(sto_pkg::OFF_CONTROL, 32'h0000_0001);
    rd_chk(4'h2, 32'h0000_0000);
    $display("test on done");
  endtask

  task automatic t_irq;
    wr_reg(sto_pkg::OFF_IRQ_CLR, 32'h0000_000F);
    wr_reg(sto_pkg::OFF_IRQ_EN, 32'h0000_0001);
    pins(1'b0, 1'b0, 6);
    fl(5'b00001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rd_chk(sto_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    wr_reg(sto_pkg::OFF_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr_reg(sto_pkg::OFF_IRQ_EN, 32'h0000_0000);
    pins(1'b1, 1'b1, 6);
    pins(1'b0, 1'b0, 6);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rd_chk(sto_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    pins(1'b1, 1'b1, 6);
    $display("test irq done");
  endtask

  // disagreement well under the timeout must not latch
  task automatic t_mis;
    pins(1'b1, 1'b0, 6);
    fl(5'b00101);
    rd_chk(sto_pkg::OFF_IRQ_STAT, 32'h0000_0003);
    wr_reg(sto_pkg::OFF_IRQ_CLR, 32'h0000_000F);
    pins(1'b1, 1'b1, 6);
    fl(5'b11000);
    $display("test short mismatch done");
  endtask

  task automatic t_sup;
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    fl(5'b00011);
    @(posedge clk);
    supply_ok <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    fl(5'b11000);
    rd_chk(sto_pkg::OFF_IRQ_STAT, 32'h0000_0009);
    wr_reg(sto_pkg::OFF_IRQ_CLR, 32'h0000_000F);
    $display("test supply done");
  endtask

  task automatic t_latch;
    pins(1'b1, 1'b0, MCYC + 10);
    pins(1'b1, 1'b1, 6);
    fl(5'b00101);
    rd_chk(sto_pkg::OFF_STATUS, 32'h0000_002B);
    rd_chk(sto_pkg::OFF_IRQ_STAT, 32'h0000_0007);
    pins(1'b0, 1'b0, 6);
    fl(5'b01101);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    pins(1'b1, 1'b1, 6);
    fl(5'b01001);
    wr_reg(sto_pkg::OFF_CONTROL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1;
    fl(5'b11000);
    $display("test latch done");
  endtask

  initial begin
    repeat (11) @(posedge clk);
    #1;
    fl(5'b00001);
    @(posedge clk);
    rstn <= 1'b1;
    t_off();
    t_on();
    t_irq();
    t_mis();
    t_sup();
    t_latch();
    report_and_stop();
  end

  // the sequence needs under two hundred cycles; this allows ample slack
  initial begin
    #125000;
    errors++;
    report_and_stop();
  end
endmodule

// file: verif/sto_ctrl_model.sv
// behavioural safety controller that drives the two torque-off channels
// assumes the bench asks for channel levels on a two-bit request
`timescale 1ns/1ps
module sto_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] want,
  output logic            out_a,
  output logic            out_b
);
  // both channels move on one edge, so any skew is only what the bench asks for
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
    end else begin
      out_a <= want[0];
      out_b <= want[1];
    end
  end
endmodule
